// >>> include/rcl_pkg.sv
// Notes on behaviour
// R1 - Software writes seconds preset bits 5:0 only with 0 to 59.
// R2 - Software writes minutes preset bits 11:6 only with 0 to 59.
// R3 - Software writes hours preset bits 16:12 only with 0 to 23.
// R4 - Weekday preset bits 19:17: 001b is Sunday; software never writes 000b.
// R5 - Day-of-month preset bits 24:20 holds 1 up to the month's length.
// R6 - Month preset bits 28:25 holds 0001b (January) to 1100b (December) only.
// R7 - Current BCD year reads at bits 13:0, 0 to 3999, reset 0x2000.
// R8 - Writable BCD year alarm value at bits 13:0, reset 0x2000.
// R9 - Writable BCD year preset at bits 13:0, reset to zero.
// R10 - Second tick every divider+1 slow clock cycles; divider resets to 0x7fff.
// R11 - Divider zero: timer tick follows slow clock, calendar tick stops.
// R12 - Delete trim-count slow pulses in every span of 1023 slow cycles.
// R13 - While calendar enabled, divider and trim writes ignored; reads return stored values.
// R14 - Setting bit 26 enables calendar and locks control register until reset.
// R15 - Current date reads with the same field layout as the preset.
// R16 - Weekday alarm 000b excludes weekday; other codes compare against current weekday.
// R17 - Enabling the calendar copies presets into the running calendar.
// R18 - Calendar rolls seconds through BCD year, honouring month length and leap years.
`default_nettype none
package rcl_pkg;

	// =========================================================
	// Register offsets
	localparam logic [7:0] OFS_DATE_NOW = 8'h00;
	localparam logic [7:0] OFS_DATE_PRESET = 8'h08;
	localparam logic [7:0] OFS_YEAR_NOW = 8'h0c;
	localparam logic [7:0] OFS_YEAR_ALARM = 8'h10;
	localparam logic [7:0] OFS_YEAR_PRESET = 8'h14;
	localparam logic [7:0] OFS_CONTROL = 8'h18;

	// =========================================================
	// Field positions
	localparam int SEC_LSB = 0;
	localparam int MIN_LSB = 6;
	localparam int HOUR_LSB = 12;
	localparam int WDAY_LSB = 17;
	localparam int MDAY_LSB = 20;
	localparam int MON_LSB = 25;
	localparam int DATE_W = 29;
	localparam int YEAR_W = 14;
	localparam int DIV_LSB = 0;
	localparam int DIV_W = 15;
	localparam int TRIM_LSB = 16;
	localparam int TRIM_W = 10;
	localparam int EN_BIT = 26;

	// =========================================================
	// Reset values
	localparam logic [YEAR_W-1:0] YEAR_NOW_RST = 14'h2000;
	localparam logic [YEAR_W-1:0] YEAR_ALARM_RST = 14'h2000;
	localparam logic [YEAR_W-1:0] YEAR_PRESET_RST = 14'h0000;
	localparam logic [DIV_W-1:0] DIV_RST = 15'h7fff;
	localparam logic [TRIM_W-1:0] TRIM_RST = 10'h000;
	localparam logic [DATE_W-1:0] DATE_PRESET_RST = 29'h0000000;
	localparam logic [2:0] WDAY_RST = 3'h1;
	localparam logic [4:0] MDAY_RST = 5'h01;
	localparam logic [3:0] MON_RST = 4'h1;

	// =========================================================
	// Counts and limits
	localparam logic [TRIM_W-1:0] TRIM_SPAN_LAST = 10'h3fe;
	localparam logic [5:0] SEC_LAST = 6'h3b;
	localparam logic [5:0] MIN_LAST = 6'h3b;
	localparam logic [4:0] HOUR_LAST = 5'h17;
	localparam logic [2:0] WDAY_LAST = 3'h7;
	localparam logic [2:0] WDAY_FIRST = 3'h1;
	localparam logic [2:0] WDAY_ANY = 3'h0;
	localparam logic [3:0] MON_LAST = 4'hc;
	localparam logic [3:0] MON_FEB = 4'h2;

endpackage
`default_nettype wire

// >>> core/rcl_month_len.sv
`timescale 1ns/1ns
`default_nettype none
module rcl_month_len
	import rcl_pkg::*;
(
	// Calendar position
	input wire logic [3:0] month,
	input wire logic [YEAR_W-1:0] year,
	// Length of the month
	output logic [4:0] days
);

	logic [3:0] ones;
	logic [3:0] tens;
	logic [3:0] hund;
	logic [3:0] thou;
	logic lo_div4;
	logic hi_div4;
	logic leap;

	// Two BCD digits t,o form a multiple of four when t even with o in 0,4,8 or t odd with o in 2,6
	function automatic logic pair_div4(input logic [3:0] t, input logic [3:0] o);
		if (!t[0]) begin
			pair_div4 = (o == 4'h0) || (o == 4'h4) || (o == 4'h8);
		end else begin
			pair_div4 = (o == 4'h2) || (o == 4'h6);
		end
	endfunction

	always_comb begin
		ones = year[3:0];
		tens = year[7:4];
		hund = year[11:8];
		thou = {2'h0, year[13:12]};
		lo_div4 = pair_div4(tens, ones);
		hi_div4 = pair_div4(thou, hund);
		leap = ((tens == 4'h0) && (ones == 4'h0)) ? hi_div4 : lo_div4; // [R18]
		unique case (month)
			4'h2: days = leap ? 5'h1d : 5'h1c;
			4'h4, 4'h6, 4'h9, 4'hb: days = 5'h1e;
			default: days = 5'h1f;
		endcase
	end

endmodule // rcl_month_len
`default_nettype wire

// >>> core/rcl_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module rcl_prescaler
	import rcl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// Slow clock pin
	input wire logic slow_clock,
	// Settings
	input wire logic [DIV_W-1:0] tick_divider,
	input wire logic [TRIM_W-1:0] trim_pulse_delete,
	// Ticks
	output logic second_tick,
	output logic timer_tick
);

	typedef struct packed {
		logic [2:0] sync;
		logic level;
		logic [TRIM_W-1:0] win;
		logic [DIV_W-1:0] cnt;
		logic sec_tick;
		logic tmr_tick;
	} rcl_pre_state_t;

	localparam rcl_pre_state_t PRE_RST = '{sync: 3'h0, level: 1'b0, win: '0, cnt: '0,
		sec_tick: 1'b0, tmr_tick: 1'b0};

	rcl_pre_state_t s;
	rcl_pre_state_t next_s;
	logic rise;
	logic keep;

	always_comb begin
		next_s = s;
		next_s.sync = {s.sync[1:0], slow_clock};
		next_s.sec_tick = 1'b0;
		next_s.tmr_tick = 1'b0;
		rise = 1'b0;
		keep = 1'b0;
		// A change counts only once the second and third stages agree
		if (s.sync[2] == s.sync[1]) begin
			next_s.level = s.sync[2];
			rise = s.sync[2] && !s.level;
		end
		if (rise) begin
			// Drop the first trim-count pulses of each 1023-cycle span
			keep = (s.win >= trim_pulse_delete); // [R12]
			next_s.win = (s.win == TRIM_SPAN_LAST) ? '0 : s.win + 10'h001; // [R12]
		end
		if (keep) begin
			if (tick_divider == '0) begin
				next_s.tmr_tick = 1'b1; // [R11]
				next_s.cnt = '0;
			end else if (s.cnt >= tick_divider) begin
				next_s.sec_tick = 1'b1; // [R10]
				next_s.tmr_tick = 1'b1;
				next_s.cnt = '0;
			end else begin
				next_s.cnt = s.cnt + 15'h0001; // [R10]
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s <= PRE_RST;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	assign second_tick = s.sec_tick;
	assign timer_tick = s.tmr_tick;

endmodule // rcl_prescaler
`default_nettype wire

// >>> core/rcl_top.sv
`timescale 1ns/1ns
`default_nettype none
module rcl_top
	import rcl_pkg::*;
(
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Slow clock pin
	input wire logic slow_clock,
	// Alarm comparison input
	input wire logic [2:0] weekday_alarm,
	// Calendar outputs
	output logic calendar_enable,
	output logic second_tick,
	output logic timer_tick,
	output logic [DATE_W-1:0] date_now,
	output logic [YEAR_W-1:0] year_now,
	output logic [YEAR_W-1:0] year_alarm,
	output logic year_match,
	output logic weekday_match
);

	// =========================================================
	// State
	typedef struct packed {
		logic [DATE_W-1:0] date_preset;
		logic [YEAR_W-1:0] year_preset;
		logic [YEAR_W-1:0] year_alarm;
		logic [DIV_W-1:0] tick_divider;
		logic [TRIM_W-1:0] trim_pulse_delete;
		logic calendar_enable;
		logic [5:0] seconds_now;
		logic [5:0] minutes_now;
		logic [4:0] hours_now;
		logic [2:0] weekday_now;
		logic [4:0] monthday_now;
		logic [3:0] month_now;
		logic [YEAR_W-1:0] year_now;
		logic wr_pend;
		logic rd_pend;
		logic [7:0] addr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic year_match;
		logic weekday_match;
	} rcl_top_state_t;

	localparam rcl_top_state_t TOP_RST = '{
		date_preset: DATE_PRESET_RST,
		year_preset: YEAR_PRESET_RST,
		year_alarm: YEAR_ALARM_RST,
		tick_divider: DIV_RST,
		trim_pulse_delete: TRIM_RST,
		calendar_enable: 1'b0,
		seconds_now: 6'h00,
		minutes_now: 6'h00,
		hours_now: 5'h00,
		weekday_now: WDAY_RST,
		monthday_now: MDAY_RST,
		month_now: MON_RST,
		year_now: YEAR_NOW_RST,
		wr_pend: 1'b0,
		rd_pend: 1'b0,
		addr: 8'h00,
		hreadyout: 1'b1,
		hrdata: 32'h00000000,
		year_match: 1'b0,
		weekday_match: 1'b0
	};

	rcl_top_state_t s;
	rcl_top_state_t next_s;
	logic [4:0] month_days;
	logic sec_tick;
	logic tmr_tick;
	logic addr_ok;
	logic [DATE_W-1:0] date_cur;
	logic [31:0] rd_word;
	logic [YEAR_W-1:0] year_inc;

	// =========================================================
	// Prescaler and month length
	rcl_prescaler u_pre (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.slow_clock(slow_clock),
		.tick_divider(s.tick_divider),
		.trim_pulse_delete(s.trim_pulse_delete),
		.second_tick(sec_tick),
		.timer_tick(tmr_tick)
	);

	rcl_month_len u_len (
		.month(s.month_now),
		.year(s.year_now),
		.days(month_days)
	);

	// =========================================================
	// BCD year step, 3999 wraps to 0
	function automatic logic [YEAR_W-1:0] bcd_year_inc(input logic [YEAR_W-1:0] y);
		logic [YEAR_W-1:0] r;
		logic carry;
		r = y;
		carry = 1'b1;
		for (int i = 0; i < 3; i++) begin
			if (carry) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					carry = 1'b0;
				end
			end
		end
		if (carry) begin
			r[13:12] = r[13:12] + 2'h1;
		end
		return r;
	endfunction

	// =========================================================
	// Read data assembly
	always_comb begin
		date_cur = '0;
		date_cur[SEC_LSB +: 6] = s.seconds_now; // [R15]
		date_cur[MIN_LSB +: 6] = s.minutes_now;
		date_cur[HOUR_LSB +: 5] = s.hours_now;
		date_cur[WDAY_LSB +: 3] = s.weekday_now;
		date_cur[MDAY_LSB +: 5] = s.monthday_now;
		date_cur[MON_LSB +: 4] = s.month_now;
		year_inc = bcd_year_inc(s.year_now);
		rd_word = 32'h00000000;
		unique case (s.addr)
			OFS_DATE_NOW: rd_word[DATE_W-1:0] = date_cur; // [R15]
			OFS_DATE_PRESET: rd_word[DATE_W-1:0] = s.date_preset;
			OFS_YEAR_NOW: rd_word[YEAR_W-1:0] = s.year_now; // [R7]
			OFS_YEAR_ALARM: rd_word[YEAR_W-1:0] = s.year_alarm; // [R8]
			OFS_YEAR_PRESET: rd_word[YEAR_W-1:0] = s.year_preset; // [R9]
			OFS_CONTROL: begin
				rd_word[DIV_LSB +: DIV_W] = s.tick_divider; // [R13]
				rd_word[TRIM_LSB +: TRIM_W] = s.trim_pulse_delete; // [R13]
				rd_word[EN_BIT] = s.calendar_enable;
			end
			default: rd_word = 32'h00000000;
		endcase
	end

	// =========================================================
	// Next state
	always_comb begin
		next_s = s;
		addr_ok = hsel && htrans[1] && hready;
		next_s.wr_pend = 1'b0;
		next_s.rd_pend = 1'b0;
		next_s.hreadyout = 1'b1;

		// Bus address phase; reads take one wait state
		if (addr_ok) begin
			next_s.addr = haddr[7:0];
			next_s.wr_pend = hwrite;
			next_s.rd_pend = !hwrite;
			next_s.hreadyout = hwrite;
		end
		if (s.rd_pend) begin
			next_s.hrdata = rd_word;
		end

		// Running calendar advances one second per tick while enabled
		if (s.calendar_enable && sec_tick) begin
			if (s.seconds_now == SEC_LAST) begin // [R18]
				next_s.seconds_now = 6'h00;
				if (s.minutes_now == MIN_LAST) begin
					next_s.minutes_now = 6'h00;
					if (s.hours_now == HOUR_LAST) begin
						next_s.hours_now = 5'h00;
						next_s.weekday_now = (s.weekday_now == WDAY_LAST) ? WDAY_FIRST :
							s.weekday_now + 3'h1; // [R18]
						if (s.monthday_now >= month_days) begin
							next_s.monthday_now = 5'h01;
							if (s.month_now == MON_LAST) begin
								next_s.month_now = 4'h1;
								next_s.year_now = year_inc; // [R18]
							end else begin
								next_s.month_now = s.month_now + 4'h1;
							end
						end else begin
							next_s.monthday_now = s.monthday_now + 5'h01;
						end
					end else begin
						next_s.hours_now = s.hours_now + 5'h01;
					end
				end else begin
					next_s.minutes_now = s.minutes_now + 6'h01;
				end
			end else begin
				next_s.seconds_now = s.seconds_now + 6'h01;
			end
		end

		// Bus data phase write
		if (s.wr_pend) begin
			unique case (s.addr)
				OFS_DATE_PRESET: next_s.date_preset = hwdata[DATE_W-1:0];
				OFS_YEAR_ALARM: next_s.year_alarm = hwdata[YEAR_W-1:0]; // [R8]
				OFS_YEAR_PRESET: next_s.year_preset = hwdata[YEAR_W-1:0]; // [R9]
				OFS_CONTROL: begin
					if (!s.calendar_enable) begin // [R13] [R14]
						next_s.tick_divider = hwdata[DIV_LSB +: DIV_W]; // [R10]
						next_s.trim_pulse_delete = hwdata[TRIM_LSB +: TRIM_W]; // [R12]
						next_s.calendar_enable = hwdata[EN_BIT]; // [R14]
						if (hwdata[EN_BIT]) begin
							// Preset fields are assumed legal by software [R1] [R2] [R3] [R4] [R5] [R6]
							next_s.seconds_now = s.date_preset[SEC_LSB +: 6]; // [R17]
							next_s.minutes_now = s.date_preset[MIN_LSB +: 6];
							next_s.hours_now = s.date_preset[HOUR_LSB +: 5];
							next_s.weekday_now = s.date_preset[WDAY_LSB +: 3];
							next_s.monthday_now = s.date_preset[MDAY_LSB +: 5];
							next_s.month_now = s.date_preset[MON_LSB +: 4];
							next_s.year_now = s.year_preset; // [R17]
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Comparison flags for the alarm logic
		next_s.year_match = (next_s.year_now == next_s.year_alarm);
		next_s.weekday_match = (weekday_alarm == WDAY_ANY) ||
			(weekday_alarm == next_s.weekday_now); // [R16]
	end

	// =========================================================
	// State register
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s <= TOP_RST;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// =========================================================
	// Outputs
	assign hreadyout = s.hreadyout;
	assign hrdata = s.hrdata;
	assign hresp = 1'b0;
	assign calendar_enable = s.calendar_enable;
	assign second_tick = sec_tick;
	assign timer_tick = tmr_tick;
	assign date_now = date_cur;
	assign year_now = s.year_now; // [R7]
	assign year_alarm = s.year_alarm;
	assign year_match = s.year_match;
	assign weekday_match = s.weekday_match;

endmodule // rcl_top
`default_nettype wire

// >>> bench/rcl_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rcl_checker
	import rcl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Calendar
	input wire logic [2:0] weekday_alarm,
	input wire logic calendar_enable,
	input wire logic second_tick,
	input wire logic timer_tick,
	input wire logic [DATE_W-1:0] date_now,
	input wire logic [YEAR_W-1:0] year_now,
	input wire logic [YEAR_W-1:0] year_alarm,
	input wire logic year_match,
	input wire logic weekday_match
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// =========================================
	// Address phase of a control write
	logic wr_ctl;
	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			wr_ctl <= 1'h0;
		else if (hready)
			wr_ctl <= hsel && htrans[1] && hwrite && haddr[7:0] == OFS_CONTROL;
	end
	sequence s_rd;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	// =========================================
	// Properties
	a_read_wait: assert property (s_rd |=> s_wait)
		else $error("read wait wrong");
	a_okay_resp: assert property (hresp == 1'h0)
		else $error("response not okay");
	a_enable_set: assert property (wr_ctl && hready && hwdata[EN_BIT] |=> calendar_enable)
		else $error("enable not set");
	a_lock_hold: assert property (calendar_enable |=> calendar_enable)
		else $error("enable dropped");
	a_tick_pair: assert property (second_tick |-> timer_tick)
		else $error("second tick without timer tick");
	a_tick_pulse: assert property (second_tick |=> !second_tick)
		else $error("second tick too long");
	a_year_match: assert property (($stable(year_now) && $stable(year_alarm)) [*3]
		|-> year_match == (year_now == year_alarm))
		else $error("year match wrong");
	a_wday_match: assert property ((rst_b && $stable(weekday_alarm) && $stable(date_now)) [*2]
		|-> weekday_match == (weekday_alarm == WDAY_ANY
		|| weekday_alarm == date_now[WDAY_LSB+:3]))
		else $error("weekday match wrong");
	a_year_bcd: assert property (year_now[3:0] <= 4'h9 && year_now[7:4] <= 4'h9
		&& year_now[11:8] <= 4'h9)
		else $error("year not bcd");
	a_date_legal: assert property (date_now[5:0] <= SEC_LAST && date_now[11:6] <= MIN_LAST
		&& date_now[16:12] <= HOUR_LAST && date_now[19:17] != WDAY_ANY)
		else $error("date field out of range");
endmodule // rcl_checker
bind rcl_top rcl_checker chk (.ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hwdata, .hreadyout, .hresp, .weekday_alarm, .calendar_enable, .second_tick,
	.timer_tick, .date_now, .year_now, .year_alarm, .year_match, .weekday_match);
`default_nettype wire

// >>> bench/test_rtc_calendar_load_and_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module test_rtc_calendar_load_and_prescaler
	import rcl_pkg::*;
;
	logic ref_clk = '0, rst_b = '0, hsel = '0, hwrite = '0, slow_clock = '0, slow_run = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r, d, y;
	logic [1:0] htrans = '0, sc = '0;
	logic [2:0] weekday_alarm = '0;
	logic hreadyout, hresp, calendar_enable, second_tick, timer_tick, year_match, weekday_match;
	logic [DATE_W-1:0] date_now;
	logic [YEAR_W-1:0] year_now, year_alarm;
	logic [31:0] exp_q[$];
	logic rd_pend = '0;
	int fail_count = 0, comparisons = 0, seed = 18069, n, gap;
	wire logic hready;
	assign hready = hreadyout;
	rcl_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'h1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .slow_clock(slow_clock),
		.weekday_alarm(weekday_alarm), .calendar_enable(calendar_enable),
		.second_tick(second_tick), .timer_tick(timer_tick), .date_now(date_now),
		.year_now(year_now), .year_alarm(year_alarm), .year_match(year_match),
		.weekday_match(weekday_match));
	// =========================================
	// Clocks and checking
	initial forever #2 ref_clk = ~ref_clk;
	// Slow clock period is eight system cycles
	always @(posedge ref_clk) begin
		weekday_alarm <= 3'($random(seed));
		if (slow_run) begin
			sc <= sc + 2'h1;
			if (sc == 2'h3)
				slow_clock <= ~slow_clock;
		end
	end
	always @(posedge ref_clk) begin
		if (rd_pend && hreadyout === 1'h1) begin
			check(hrdata, exp_q.pop_front());
			rd_pend <= 1'h0;
		end
		if (hsel && htrans[1] && hready && !hwrite)
			rd_pend <= 1'h1;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// =========================================
	// Bus and tick tasks
	task automatic wait_rdy;
		int k;
		k = 0;
		@(posedge ref_clk);
		while (hreadyout !== 1'h1) begin
			k++;
			if (k > 40) begin
				fail_count++;
				print_verdict;
			end
			@(posedge ref_clk);
		end
	endtask
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] v);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= v;
		wait_rdy;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'h0, 32'h0);
	endtask
	task automatic tick_gap(input logic s, output int g);
		g = 1;
		@(posedge ref_clk);
		while ((s ? second_tick : timer_tick) !== 1'h1) begin
			g++;
			if (g > 9000) begin
				fail_count++;
				print_verdict;
			end
			@(posedge ref_clk);
		end
	endtask
	// =========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'h1;
		rd(32'h0c, 32'h2000);
		rd(32'h10, 32'h2000);
		rd(32'h14, 32'h0);
		rd(32'h18, 32'h7fff);
		rd(32'h00, {3'h0, 4'h1, 5'h1, 3'h1, 17'h0});
		for (int i = 0; i < 3; i++) begin
			r = $random(seed);
			d = {3'h0, r[3:0] % 4'hc + 4'h1, r[8:4] % 5'h1c + 5'h1, r[11:9] % 3'h7 + 3'h1,
				r[16:12] % 5'h18, r[22:17] % 6'h3c, r[28:23] % 6'h3c};
			bus(32'h08, 1'h1, d);
			rd(32'h08, d);
		end
		r = $random(seed);
		y = {18'h0, r[13:12], r[11:8] % 4'ha, r[7:4] % 4'ha, r[3:0] % 4'ha};
		bus(32'h10, 1'h1, y);
		rd(32'h10, y);
		bus(32'h14, 1'h1, y);
		rd(32'h14, y);
		bus(32'h0c, 1'h1, 32'h0);
		rd(32'h0c, 32'h2000);
		bus(32'h40, 1'h1, 32'hffffffff);
		rd(32'h40, 32'h0);
		slow_run <= 1'h1;
		bus(32'h18, 1'h1, 32'h3);
		rd(32'h18, 32'h3);
		tick_gap(1'h1, gap);
		tick_gap(1'h1, gap);
		check(gap, 32'h20);
		bus(32'h18, 1'h1, 32'h0);
		tick_gap(1'h0, gap);
		tick_gap(1'h0, gap);
		check(gap, 32'h8);
		n = 0;
		repeat (200) begin
			@(posedge ref_clk);
			if (second_tick !== 1'h0)
				n++;
		end
		check(n, 32'h0);
		bus(32'h18, 1'h1, 32'h03ff0000);
		rd(32'h18, 32'h03ff0000);
		n = 0;
		repeat (30) @(posedge ref_clk);
		repeat (300) begin
			@(posedge ref_clk);
			if (timer_tick !== 1'h0)
				n++;
		end
		check(n, 32'h0);
		// One kept edge per 1023 slow edges: 1023 slow periods of eight cycles
		bus(32'h18, 1'h1, 32'h03fe0000);
		tick_gap(1'h0, gap);
		tick_gap(1'h0, gap);
		check(gap, 32'h1ff8);
		slow_run <= 1'h0;
		d = {3'h0, 4'hc, 5'h1f, 3'h7, 5'h17, 6'h3b, 6'h3b};
		bus(32'h08, 1'h1, d);
		bus(32'h14, 1'h1, 32'h1999);
		bus(32'h10, 1'h1, 32'h2000);
		bus(32'h18, 1'h1, 32'h04000001);
		rd(32'h00, d);
		rd(32'h0c, 32'h1999);
		bus(32'h18, 1'h1, 32'h0);
		rd(32'h18, 32'h04000001);
		slow_run <= 1'h1;
		tick_gap(1'h1, gap);
		slow_run <= 1'h0;
		repeat (2) @(posedge ref_clk);
		rd(32'h00, {3'h0, 4'h1, 5'h1, 3'h1, 17'h0});
		rd(32'h0c, 32'h2000);
		check({31'h0, year_match}, 32'h1);
		// Reset in mid-run clears the lock; then a leap-year February roll
		rst_b <= 1'h0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'h1;
		rd(32'h18, 32'h7fff);
		d = {3'h0, 4'h2, 5'h1c, 3'h3, 5'h17, 6'h3b, 6'h3b};
		bus(32'h08, 1'h1, d);
		bus(32'h14, 1'h1, 32'h2000);
		bus(32'h18, 1'h1, 32'h04000001);
		slow_run <= 1'h1;
		tick_gap(1'h1, gap);
		slow_run <= 1'h0;
		repeat (2) @(posedge ref_clk);
		rd(32'h00, {3'h0, 4'h2, 5'h1d, 3'h4, 17'h0});
		rd(32'h0c, 32'h2000);
		print_verdict;
	end
endmodule // test_rtc_calendar_load_and_prescaler
`default_nettype wire
